// >>> core/pecp_consts.svh
// Purpose: Constants for the performance event counter pairs
// Assumes: Included by the package and by every design file
// Notes:   Bit positions refer to the 32-bit control word
`ifndef PECP_CONSTS_SVH
`define PECP_CONSTS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PECP_NUM_PAIRS 2
`define PECP_SEL_W 4
`define PECP_EVT_W 6
`define PECP_NUM_EVT 64
`define PECP_DATA_W 64
`define PECP_NARROW_W 32

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define PECP_BIT_MORE 31
`define PECP_BIT_WIDE 30
`define PECP_RSVD_HI 29
`define PECP_RSVD_LO 11
`define PECP_EVT_HI 10
`define PECP_EVT_LO 5
`define PECP_BIT_IE 4
`define PECP_BIT_USER 3
`define PECP_BIT_SUP 2
`define PECP_BIT_KERN 1
`define PECP_BIT_EXL 0

// ----------------------------------------
// Presets and reset values
// ----------------------------------------
`define PECP_WIDE_FLAGS 2'b10
`define PECP_HAS_SUP 1'b1
`define PECP_IE_RESET 1'b0
`define PECP_EVT_RESET 6'h00
`define PECP_COUNT_RESET 64'h0000_0000_0000_0000

`endif

// >>> core/pecp_counter.sv
// Purpose: One event counter, 32 or 64 bits wide
// Assumes: Width preset per instance, never changed at run time
// Notes:   Software write takes precedence over an increment
`timescale 1ns/1ps
`default_nettype none
`include "pecp_consts.svh"

module pecp_counter #(
  parameter logic WIDE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [`PECP_DATA_W-1:0] wdata,
  input wire logic inc,
  output logic [`PECP_DATA_W-1:0] count,
  output logic ovf
);
  import pecp_pkg::*;

  logic [`PECP_DATA_W-1:0] cnt_r;
  logic [`PECP_DATA_W-1:0] cnt_nxt;

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (we) begin
      if (WIDE) begin
        cnt_nxt = wdata;
      end else begin
        cnt_nxt = {32'h0000_0000, wdata[`PECP_NARROW_W-1:0]};
      end
    end else if (inc) begin
      // Wraps and keeps going past overflow
      if (WIDE) begin
        cnt_nxt = cnt_r + 64'h0000_0000_0000_0001;
      end else begin
        cnt_nxt = {32'h0000_0000, cnt_r[`PECP_NARROW_W-1:0] + 32'h0000_0001};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `PECP_COUNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign ovf = WIDE ? cnt_r[`PECP_DATA_W-1] : cnt_r[`PECP_NARROW_W-1];

endmodule
`default_nettype wire

// >>> core/pecp_pkg.sv
// Purpose: Types for the performance event counter pairs
// Assumes: Constants header is on the include path
// Notes:   Mode enum carries the core's current privilege level
`default_nettype none
`include "pecp_consts.svh"

package pecp_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    pecp_user,
    pecp_supervisor,
    pecp_kernel
  } pecp_mode_type;

  typedef struct packed {
    logic [`PECP_EVT_W-1:0] evt;
    logic ie;
    logic user_en;
    logic sup_en;
    logic kern_en;
    logic exl_en;
  } pecp_ctl_type;

endpackage
`default_nettype wire

// >>> core/pecp_top.sv
// Purpose: Performance event counter pairs on the system register port
// Assumes: Core drives events and privilege state on this clock
// Notes:   Selects 0 and 2 reach control words, 1 and 3 the counters
`timescale 1ns/1ps
`default_nettype none
`include "pecp_consts.svh"

// Functional notes
// - Width flag one gives a 64-bit counter
// - Width flag zero gives 32 bits; preset
// - Control bits 29..11 read zero
// - Bits 10..5 select the counted event
// - Bit 4 enables overflow request, resets 0
// - Overflow while counter top bit is one
// - Bit 3 permits counting in user mode
// - Bit 2 permits counting in supervisor mode
// - No supervisor: bit 2 ignored, reads zero
// - Bit 1 counts kernel only outside exception/error
// - Bit 0 counts at exception level, no error
// - Never count at error level or debug
// - Increment once per enabled event; software access
// - Pending requests ORed into one pending bit
// - Counting continues after overflow
// - Even select control, odd counter; more flag
module pecp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PECP_SEL_W-1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [`PECP_DATA_W-1:0] reg_wdata,
  output logic [`PECP_DATA_W-1:0] reg_rdata,
  input wire logic [`PECP_NUM_EVT-1:0] event_pulse,
  input wire pecp_pkg::pecp_mode_type mode,
  input wire logic exception_level,
  input wire logic error_level,
  input wire logic debug_mode_flag,
  output logic overflow_irq
);
  import pecp_pkg::*;

  localparam int NP = `PECP_NUM_PAIRS;
  localparam logic [NP-1:0] WIDE_FLAGS = `PECP_WIDE_FLAGS;
  localparam logic HAS_SUP = `PECP_HAS_SUP;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  pecp_ctl_type ctl_r [NP];
  pecp_ctl_type ctl_nxt [NP];
  logic [`PECP_DATA_W-1:0] count [NP];
  logic ovf [NP];
  logic inc [NP];
  logic cnt_we [NP];
  logic qual [NP];
  logic [`PECP_NARROW_W-1:0] ctl_img [NP];
  logic [`PECP_DATA_W-1:0] rdata_r;
  logic [`PECP_DATA_W-1:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic quiet;

  // ----------------------------------------
  // Mode qualification
  // ----------------------------------------
  // Error level and debug shut everything off first
  assign quiet = error_level | debug_mode_flag;

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      qual[i] = 1'b0;
      if (!quiet) begin
        if (exception_level) begin
          qual[i] = ctl_r[i].exl_en;
        end else begin
          case (mode)
            pecp_user: begin
              qual[i] = ctl_r[i].user_en;
            end
            pecp_supervisor: begin
              qual[i] = ctl_r[i].sup_en & HAS_SUP;
            end
            pecp_kernel: begin
              qual[i] = ctl_r[i].kern_en;
            end
            default: begin
              qual[i] = 1'b0;
            end
          endcase
        end
      end
      // One pulse per cycle from the core is one count
      inc[i] = qual[i] & event_pulse[ctl_r[i].evt];
    end
  end

  // ----------------------------------------
  // Control words
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      ctl_nxt[i] = ctl_r[i];
      if (reg_wr && (reg_sel == `PECP_SEL_W'(2 * i))) begin
        // Reserved, width and more bits are not stored
        ctl_nxt[i].evt = reg_wdata[`PECP_EVT_HI:`PECP_EVT_LO];
        ctl_nxt[i].ie = reg_wdata[`PECP_BIT_IE];
        ctl_nxt[i].user_en = reg_wdata[`PECP_BIT_USER];
        // Without supervisor mode the bit stays zero
        ctl_nxt[i].sup_en = reg_wdata[`PECP_BIT_SUP] & HAS_SUP;
        ctl_nxt[i].kern_en = reg_wdata[`PECP_BIT_KERN];
        ctl_nxt[i].exl_en = reg_wdata[`PECP_BIT_EXL];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        ctl_r[i].evt <= `PECP_EVT_RESET;
        ctl_r[i].ie <= `PECP_IE_RESET;
        ctl_r[i].user_en <= 1'b0;
        ctl_r[i].sup_en <= 1'b0;
        ctl_r[i].kern_en <= 1'b0;
        ctl_r[i].exl_en <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        ctl_r[i] <= ctl_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Counter write strobes
  // ----------------------------------------
  // An event in the same cycle as a write is lost
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      cnt_we[i] = reg_wr && (reg_sel == `PECP_SEL_W'(2 * i + 1));
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  for (genvar g = 0; g < NP; g++) begin : g_pair
    pecp_counter #(
      .WIDE(WIDE_FLAGS[g])
    ) u_cnt (
      .clk(clk),
      .rst(rst),
      .we(cnt_we[g]),
      .wdata(reg_wdata),
      .inc(inc[g]),
      .count(count[g]),
      .ovf(ovf[g])
    );
  end

  // ----------------------------------------
  // Control read image
  // ----------------------------------------
  // Reserved bits take the cleared default, never storage
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      ctl_img[i] = '0;
      ctl_img[i][`PECP_BIT_MORE] = (i < NP - 1);
      ctl_img[i][`PECP_BIT_WIDE] = WIDE_FLAGS[i];
      ctl_img[i][`PECP_RSVD_HI:`PECP_RSVD_LO] = '0;
      ctl_img[i][`PECP_EVT_HI:`PECP_EVT_LO] = ctl_r[i].evt;
      ctl_img[i][`PECP_BIT_IE] = ctl_r[i].ie;
      ctl_img[i][`PECP_BIT_USER] = ctl_r[i].user_en;
      ctl_img[i][`PECP_BIT_SUP] = ctl_r[i].sup_en;
      ctl_img[i][`PECP_BIT_KERN] = ctl_r[i].kern_en;
      ctl_img[i][`PECP_BIT_EXL] = ctl_r[i].exl_en;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Registered read costs a cycle but keeps the output clean
  always_comb begin
    rdata_nxt = '0;
    for (int i = 0; i < NP; i++) begin
      if (reg_sel == `PECP_SEL_W'(2 * i)) begin
        // Upper half of a control read stays zero
        rdata_nxt[`PECP_NARROW_W-1:0] = ctl_img[i];
      end else if (reg_sel == `PECP_SEL_W'(2 * i + 1)) begin
        rdata_nxt = count[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Pending request
  // ----------------------------------------
  // Raw level; the core applies its own global masks
  always_comb begin
    irq_nxt = 1'b0;
    for (int i = 0; i < NP; i++) begin
      irq_nxt = irq_nxt | (ctl_r[i].ie & ovf[i]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign overflow_irq = irq_r;

endmodule
`default_nettype wire

// >>> verif/pecp_chk_sva.sv
// Purpose: Port checks for the counter pairs
// Assumes: Read data lags the select by one edge
// Notes: Flag checks skip the edges just after reset
`timescale 1ns/1ps
`default_nettype none
module pecp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic error_level,
  input wire logic debug_mode_flag,
  input wire logic overflow_irq
);
  import pecp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Sequences
  // ----
  sequence s_quiet;
    reg_sel == 4'h1 && !reg_wr && (error_level || debug_mode_flag);
  endsequence
  sequence s_wr(logic [3:0] s);
    reg_wr && reg_sel == s ##1 reg_sel == s && !reg_wr;
  endsequence
  property p_echo(logic [3:0] s, logic [63:0] m);
    s_wr(s) |-> ##1 (reg_rdata & m) == ($past(reg_wdata, 2) & m);
  endproperty
  // ----
  // Checks
  // ----
  chk_ctl_zero_bits: assert property (
    !$past(reg_sel[0]) |-> reg_rdata[63:32] == 32'h0 && reg_rdata[29:11] == 19'h0)
    else $error("control reserved bits not zero");
  chk_unmapped_zero: assert property (
    $past(reg_sel) > 4'h3 |-> reg_rdata == 64'h0) else $error("unmapped select not zero");
  chk_ctr0_narrow: assert property (
    $past(reg_sel) == 4'h1 |-> reg_rdata[63:32] == 32'h0) else $error("counter 0 too wide");
  chk_pair0_flags: assert property (
    !$past(rst) && !$past(rst, 2) && $past(reg_sel) == 4'h0 |-> reg_rdata[31:30] == 2'b10)
    else $error("pair 0 flags wrong");
  chk_pair1_flags: assert property (
    !$past(rst) && !$past(rst, 2) && $past(reg_sel) == 4'h2 |-> reg_rdata[31:30] == 2'b01)
    else $error("pair 1 flags wrong");
  chk_err_freeze: assert property (
    s_quiet [*2] |-> ##1 $stable(reg_rdata)) else $error("counted at error or debug");
  chk_irq_reset: assert property (
    $past(rst) |-> !overflow_irq) else $error("request high after reset");
  chk_ctl_echo: assert property (p_echo(4'h0, 64'h7ff))
    else $error("control write lost");
  chk_ctr0_echo: assert property (p_echo(4'h1, 64'hffff_ffff))
    else $error("counter 0 write lost");
endmodule
bind pecp_top pecp_chk u_chk (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .error_level(error_level),
  .debug_mode_flag(debug_mode_flag), .overflow_irq(overflow_irq));
`default_nettype wire

// >>> verif/pecp_core_model.sv
// Purpose: Core side: event pulses and privilege state
// Assumes: Bench changes inputs at the falling edge
// Notes: One event code per cycle keeps the model small
`timescale 1ns/1ps
`default_nettype none
module pecp_core_model (
  input wire logic fire,
  input wire logic [5:0] code,
  input wire logic [4:0] state,
  output logic [63:0] event_pulse,
  output var pecp_pkg::pecp_mode_type mode,
  output logic exception_level,
  output logic error_level,
  output logic debug_mode_flag
);
  import pecp_pkg::*;
  assign event_pulse = fire ? (64'h1 << code) : 64'h0;
  assign mode = pecp_mode_type'(state[4:3]);
  assign exception_level = state[2];
  assign error_level = state[1];
  assign debug_mode_flag = state[0];
endmodule
`default_nettype wire

// >>> verif/perf_event_counter_pair_tb_top.sv
// Purpose: Directed bench for the counter pairs
// Assumes: Pair 0 narrow, pair 1 wide, supervisor present
// Notes: Undefined resets are taken as zero
`timescale 1ns/1ps
`default_nettype none
module perf_event_counter_pair_tb_top;
  import pecp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_sel = 4'h0;
  logic reg_wr = 1'b0;
  logic [63:0] reg_wdata = 64'h0;
  logic [63:0] reg_rdata, event_pulse;
  pecp_mode_type mode;
  logic exception_level, error_level, debug_mode_flag, overflow_irq;
  logic fire = 1'b0;
  logic [5:0] code = 6'h0;
  logic [4:0] state = 5'h0;
  logic [9:0] tbl [10] = '{10'h201, 10'h1c0, 10'h111, 10'h2d0, 10'h0a1,
    10'h0a8, 10'h069, 10'h3a8, 10'h3e4, 10'h3c2};
  int failures = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  pecp_core_model u_core (.fire(fire), .code(code), .state(state), .event_pulse(event_pulse),
    .mode(mode), .exception_level(exception_level), .error_level(error_level),
    .debug_mode_flag(debug_mode_flag));
  pecp_top u_dut (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_pulse(event_pulse), .mode(mode),
    .exception_level(exception_level), .error_level(error_level),
    .debug_mode_flag(debug_mode_flag), .overflow_irq(overflow_irq));
  task end_of_test;
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [3:0] s, input logic [63:0] d);
    @(negedge clk);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Read data lags the select by one edge; the task waits two falling edges
  task rd(input logic [3:0] s, input logic [63:0] e);
    @(negedge clk);
    reg_sel = s;
    repeat (2) @(negedge clk);
    n_tests++;
    if (reg_rdata !== e) begin
      failures++;
      $display("[ERR] %0t select %h read %h", $time, s, reg_rdata);
    end
  endtask
  task chk_irq(input logic e);
    n_tests++;
    if (overflow_irq !== e) begin
      failures++;
      $display("[ERR] %0t overflow request %b", $time, overflow_irq);
    end
  endtask
  task pulse(input logic [5:0] c, input int n);
    repeat (n) begin
      @(negedge clk);
      code = c;
      fire = 1'b1;
    end
    @(negedge clk);
    fire = 1'b0;
  endtask
  task s_reset;
    rd(4'h0, 64'h8000_0000);
    rd(4'h2, 64'h4000_0000);
    chk_irq(1'b0);
    wr(4'h0, '1);
    rd(4'h0, 64'h8000_07ff);
    wr(4'h6, '1);
    rd(4'h6, 64'h0);
  endtask
  // Entry: control bits 3..0, mode, exception, error, debug, counts
  task s_modes;
    for (int i = 0; i < 10; i++) begin
      wr(4'h0, {53'h0, 6'h05, 1'b0, tbl[i][9:6]});
      state = tbl[i][5:1];
      wr(4'h1, 64'h0);
      pulse(6'h05, 3);
      pulse(6'h06, 1);
      rd(4'h1, tbl[i][0] ? 64'h3 : 64'h0);
    end
  endtask
  task s_ovf;
    state = 5'h0;
    wr(4'h0, 64'h18);
    wr(4'h1, 64'hffff_ffff_7fff_ffff);
    rd(4'h1, 64'h7fff_ffff);
    chk_irq(1'b0);
    pulse(6'h00, 1);
    rd(4'h1, 64'h8000_0000);
    chk_irq(1'b1);
    pulse(6'h00, 1);
    rd(4'h1, 64'h8000_0001);
    wr(4'h0, 64'h8);
    rd(4'h0, 64'h8000_0008);
    chk_irq(1'b0);
    wr(4'h2, 64'h18);
    wr(4'h3, 64'hffff_ffff);
    pulse(6'h00, 1);
    rd(4'h3, 64'h1_0000_0000);
    chk_irq(1'b0);
    wr(4'h3, 64'h7fff_ffff_ffff_ffff);
    pulse(6'h00, 1);
    rd(4'h3, 64'h8000_0000_0000_0000);
    chk_irq(1'b1);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    s_reset;
    s_modes;
    s_ovf;
    end_of_test;
  end
  // Guards against a hang anywhere in the sequence
  initial begin
    #2000000;
    failures++;
    $display("[ERR] %0t run did not finish in time", $time);
    end_of_test;
  end
endmodule
`default_nettype wire
